// *** logic/motor_pwm_fault_gating.sv ***
// Purpose: pulse-width and protection gating of the six drive outputs
// Assumes: all inputs synchronous to pclk; decode comes from outside
// Notes:   high-side drives and fault are active low
// Function
// (R1) ramp discharge sets both latches, enabling top and bottom drives; here the latches gate the bottom drives only
// (R2) speed comparator clears upper latch, ending bottom drive for the cycle
// (R3) speed chopping applies to bottom drives only, never top drives
// (R4) over-current turns conduction off at once for rest of ramp
// (R5) current comparator clears lower latch and ends conduction
// (R6) fault asserted while over-current is detected
// (R7) at most one bottom pulse per oscillator cycle, no retrigger
// (R8) any undervoltage flag: fault, top drives off, bottom drives low
// (R9) fault low on bad code, enable low, over-current, undervoltage, thermal
// (R10) thermal shutdown acts exactly like output enable low
// (R11) fault and top drives are active low
// (R12) bottom drive = decode AND speed latch AND current latch
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module motor_pwm_fault_gating
    import motor_gate_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ramp_discharge,
    input  wire logic        speed_cmp,
    input  wire logic        current_cmp,
    input  wire logic        uv_main_supply_rail,
    input  wire logic        uv_lowside_supply,
    input  wire logic        uv_reference,
    input  wire logic        thermal_shutdown,
    input  wire logic        sensor_code_bad,
    input  wire logic        output_enable,
    input  wire logic [2:0]  top_select,
    input  wire logic [2:0]  bottom_select,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [2:0]  top_drive_n,
    output logic      [2:0]  bottom_drive,
    output logic             fault_n,
    output logic             irq
);
    prot_s            prot;
    logic             speed_q;
    logic             current_q;
    logic             uv_any;
    logic             disable_any;
    logic             fault_d;
    logic             sw_off_q;
    logic [31:0]      cycles_q;
    logic [EVT_W-1:0] raw_evt;
    logic [EVT_W-1:0] sticky;
    logic [EVT_W-1:0] mask;
    logic             irq_int;
    logic             acc;
    logic             wr;
    logic             rd;
    logic             hit;

    assign prot = '{uv_main:     uv_main_supply_rail,
                    uv_lowside:  uv_lowside_supply,
                    uv_ref:      uv_reference,
                    thermal:     thermal_shutdown,
                    bad_code:    sensor_code_bad,
                    enable_low:  ~output_enable,
                    overcurrent: current_cmp};

    dual_latch u_latch (
        .pclk         (pclk),
        .presetn      (presetn),
        .discharge    (ramp_discharge),  // R1
        .speed_trip   (speed_cmp),       // R2
        .current_trip (current_cmp),     // R5
        .speed_q      (speed_q),
        .current_q    (current_q)
    );

    assign uv_any      = prot.uv_main | prot.uv_lowside | prot.uv_ref;
    // thermal folds into the same path as enable low
    assign disable_any = prot.enable_low | prot.thermal | sw_off_q;  // R10
    assign fault_d     = prot.bad_code | prot.enable_low | prot.overcurrent
                       | uv_any | prot.thermal;  // R9 R6

    // current_cmp also gates directly so the trip cycle never conducts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bottom_drive <= 3'h0;
        end else if (uv_any || disable_any || prot.bad_code) begin
            bottom_drive <= 3'h0;  // R8
        end else begin
            bottom_drive <= bottom_select & {3{speed_q & current_q
                            & ~speed_cmp & ~current_cmp}};  // R12 R4 R7
        end
    end

    // top drives ignore the speed latch: no chopping up top
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_drive_n <= DRIVE_OFF_HI;
        end else if (uv_any || prot.bad_code) begin
            top_drive_n <= DRIVE_OFF_HI;  // R8
        end else if (disable_any) begin
            top_drive_n <= 3'h0;  // R10
        end else begin
            top_drive_n <= ~top_select;  // R3 R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_n <= 1'b1;
        end else begin
            fault_n <= ~(fault_d | sw_off_q);  // R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycles_q <= 32'h0000_0000;
        end else if (ramp_discharge) begin
            cycles_q <= cycles_q + 32'h0000_0001;
        end
    end

    assign raw_evt = {prot.bad_code, prot.thermal, uv_any, prot.overcurrent};

    assign acc = psel & penable;
    // writes commit on the edge at which the master sees pready
    assign wr  = acc & pwrite & pready;
    assign rd  = acc & ~pwrite;
    assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_EVENT)
              || (paddr == ADDR_MASK) || (paddr == ADDR_CYCLES);

    event_regs u_evt (
        .pclk     (pclk),
        .presetn  (presetn),
        .raw      (raw_evt),
        .clr      ((wr && paddr == ADDR_EVENT) ? pwdata[EVT_W-1:0] : 4'h0),
        .mask_wr  (pwdata[EVT_W-1:0]),
        .mask_we  (wr && paddr == ADDR_MASK),
        .sticky_q (sticky),
        .mask_q   (mask),
        .irq_q    (irq_int)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_off_q <= CTRL_RESET[0];
        end else if (wr && paddr == ADDR_CTRL) begin
            sw_off_q <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_int;
        end
    end

    // one wait state: pready follows the first access edge, then drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~hit;
            prdata  <= 32'h0000_0000;
            if (rd && !pready) begin
                case (paddr)
                    ADDR_CTRL:   prdata <= {31'h0, sw_off_q};
                    ADDR_STATUS: prdata <= {24'h0, speed_q, current_q, ~fault_n,
                                            prot.enable_low, uv_any, prot.thermal,
                                            prot.bad_code, prot.overcurrent};
                    ADDR_EVENT:  prdata <= {28'h0, sticky};
                    ADDR_MASK:   prdata <= {28'h0, mask};
                    ADDR_CYCLES: prdata <= cycles_q;
                    default:     prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // read data is loaded once and stands only in the pready cycle

    chk_latch_set: assert property (@(posedge pclk) disable iff (!presetn)  // R1
        ramp_discharge && !speed_cmp && !current_cmp |=> speed_q && current_q)
        else $error("latches not set at discharge");
    chk_speed_clear: assert property (@(posedge pclk) disable iff (!presetn)  // R2
        speed_cmp |=> !speed_q ##1 (bottom_drive == 3'h0 || $past(ramp_discharge)))
        else $error("speed trip did not end pulse");
    chk_top_unchopped: assert property (@(posedge pclk) disable iff (!presetn)  // R3
        !uv_any && !prot.bad_code && !disable_any && !speed_q
        |=> top_drive_n == ~$past(top_select))
        else $error("top drive was chopped");
    chk_oc_off: assert property (@(posedge pclk) disable iff (!presetn)  // R4 R5
        current_cmp |=> bottom_drive == 3'h0)
        else $error("over-current did not cut drive");
    chk_oc_fault: assert property (@(posedge pclk) disable iff (!presetn)  // R6
        current_cmp |=> !fault_n)
        else $error("fault missing on over-current");
    chk_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)  // R7
        $fell(|bottom_drive) && !$past(ramp_discharge) && !ramp_discharge
        |=> bottom_drive == 3'h0)
        else $error("pulse retriggered in cycle");
    chk_uv_off: assert property (@(posedge pclk) disable iff (!presetn)  // R8
        uv_any |=> top_drive_n == DRIVE_OFF_HI && bottom_drive == 3'h0 && !fault_n)
        else $error("undervoltage not honoured");
    chk_fault_causes: assert property (@(posedge pclk) disable iff (!presetn)  // R9
        !fault_n |-> $past(fault_d | sw_off_q))
        else $error("fault without cause");
    chk_thermal_same: assert property (@(posedge pclk) disable iff (!presetn)  // R10 R11
        thermal_shutdown && !uv_any && !sensor_code_bad
        |=> top_drive_n == 3'h0 && bottom_drive == 3'h0 && !fault_n)
        else $error("thermal differs from enable low");
    chk_and_gate: assert property (@(posedge pclk) disable iff (!presetn)  // R12
        |bottom_drive |-> $past(speed_q && current_q))
        else $error("bottom conducted with a latch clear");
    chk_top_on_trip: assert property (@(posedge pclk) disable iff (!presetn)  // R3
        speed_cmp && !uv_any && !prot.bad_code && !disable_any
        |=> top_drive_n == ~$past(top_select))
        else $error("speed trip touched top drive");
    chk_cur_latch: assert property (@(posedge pclk) disable iff (!presetn)  // R5
        current_cmp
        |=> !current_q)
        else $error("current latch not cleared");
    chk_enable_off: assert property (@(posedge pclk) disable iff (!presetn)  // R10
        (!output_enable || sw_off_q) && !uv_any && !sensor_code_bad
        |=> top_drive_n == 3'h0 && bottom_drive == 3'h0 && !fault_n)
        else $error("enable low not honoured");
    chk_bad_code: assert property (@(posedge pclk) disable iff (!presetn)  // R9
        sensor_code_bad
        |=> top_drive_n == DRIVE_OFF_HI && bottom_drive == 3'h0 && !fault_n)
        else $error("bad code not honoured");
    chk_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)  // R9
        !fault_d && !sw_off_q
        |=> fault_n)
        else $error("fault without cause held");
    // register bus and event guards
    chk_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        pready
        |=> !pready)
        else $error("pready held too long");
    chk_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready
        |=> pready)
        else $error("access not answered");
    chk_slverr_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr
        |-> pready)
        else $error("pslverr without pready");
    chk_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !hit
        |=> pslverr)
        else $error("unmapped access not refused");
    chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !pready
        |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ADDR_CTRL
        |=> sw_off_q == $past(pwdata[0]))
        else $error("control write lost");
    chk_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ADDR_MASK
        |=> mask == $past(pwdata[EVT_W-1:0]))
        else $error("mask write lost");
    chk_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        |raw_evt
        |=> (sticky & $past(raw_evt)) == $past(raw_evt))
        else $error("event not latched");
    chk_event_clear: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ADDR_EVENT
        |=> (sticky & $past(pwdata[EVT_W-1:0] & ~raw_evt)) == 4'h0)
        else $error("event not cleared");
    chk_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        |(sticky & mask)
        |-> ##2 irq)
        else $error("irq missing");
    chk_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !(|(sticky & mask))
        |-> ##2 !irq)
        else $error("irq without event");
    chk_cycle_count: assert property (@(posedge pclk) disable iff (!presetn)
        ramp_discharge
        |=> cycles_q == $past(cycles_q) + 32'h0000_0001)
        else $error("discharge not counted");
endmodule : motor_pwm_fault_gating

// *** logic/motor_gate_pkg.sv ***
// Purpose: shared constants and types for the drive gating block
// Assumes: comparator and supply flags arrive already digitised on pclk
// Notes:   register map and event bit layout live here
package motor_gate_pkg;

    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_EVENT  = 12'h008;
    localparam logic [11:0] ADDR_MASK   = 12'h00C;
    localparam logic [11:0] ADDR_CYCLES = 12'h010;

    localparam int EVT_W         = 4;
    localparam int EVT_OVERCUR   = 0;
    localparam int EVT_UNDERV    = 1;
    localparam int EVT_THERMAL   = 2;
    localparam int EVT_BADCODE   = 3;

    localparam logic [31:0]      CTRL_RESET  = 32'h0000_0000;
    localparam logic [EVT_W-1:0] MASK_RESET  = 4'h0;
    localparam logic [2:0]       DRIVE_OFF_HI = 3'h7;

    // digitised protection inputs
    typedef struct packed {
        logic       uv_main;
        logic       uv_lowside;
        logic       uv_ref;
        logic       thermal;
        logic       bad_code;
        logic       enable_low;
        logic       overcurrent;
    } prot_s;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ON,
        PH_DONE
    } phase_e;

endpackage : motor_gate_pkg

// *** logic/dual_latch.sv ***
// Purpose: set/reset latch pair that shapes one pulse per ramp cycle
// Assumes: discharge is a one-cycle pulse at ramp reset
// Notes:   set at discharge; a clear in the discharge cycle still clears
`timescale 1ns/100ps
module dual_latch
    import motor_gate_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic discharge,
    input  wire logic speed_trip,
    input  wire logic current_trip,
    output logic      speed_q,
    output logic      current_q
);
    // clear wins: protection must not be overridden by a late set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_q <= 1'b0;
        end else if (speed_trip) begin
            speed_q <= 1'b0;
        end else if (discharge) begin
            speed_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_q <= 1'b0;
        end else if (current_trip) begin
            current_q <= 1'b0;
        end else if (discharge) begin
            current_q <= 1'b1;
        end
    end
endmodule : dual_latch

// *** logic/event_regs.sv ***
// Purpose: sticky event bits with write-one-to-clear and a mask
// Assumes: raw events are levels or pulses on pclk
// Notes:   set wins over a simultaneous clear
`timescale 1ns/100ps
module event_regs
    import motor_gate_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [EVT_W-1:0] raw,
    input  wire logic [EVT_W-1:0] clr,
    input  wire logic [EVT_W-1:0] mask_wr,
    input  wire logic             mask_we,
    output logic      [EVT_W-1:0] sticky_q,
    output logic      [EVT_W-1:0] mask_q,
    output logic                  irq_q
);
    genvar i;
    generate
        for (i = 0; i < EVT_W; i++) begin : g_evt
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sticky_q[i] <= 1'b0;
                end else if (raw[i]) begin
                    sticky_q[i] <= 1'b1;
                end else if (clr[i]) begin
                    sticky_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= MASK_RESET;
        end else if (mask_we) begin
            mask_q <= mask_wr;
        end
    end

    // one cycle behind the sticky bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sticky_q & mask_q);
        end
    end
endmodule : event_regs

// *** sim/power_stage_model.sv ***
// Purpose: behavioural power switches on the six drive lines
// Assumes: top switch on while its drive is low
// Notes:   flags any leg with both switches on at once
`timescale 1ns/100ps
module power_stage_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] top_drive_n,
    input  wire logic [2:0] bottom_drive,
    output logic      [2:0] leg_high,
    output logic            shorted_q
);
    assign leg_high = ~top_drive_n;
    // both switches of one leg on would short the supply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shorted_q <= 1'b0;
        end else if (|(leg_high & bottom_drive)) begin
            shorted_q <= 1'b1;
        end
    end
endmodule : power_stage_model

// *** sim/tb_motor_pwm_fault_gating.sv ***
// Purpose: self-checking bench for the drive gating block
// Assumes: a check at an edge sees what the previous edge launched
// Notes:   table rows first, then chopping, trips and registers
`timescale 1ns/100ps
module tb_motor_pwm_fault_gating;
    import motor_gate_pkg::*;
    typedef struct packed {
        logic [2:0] uv;
        logic       th, bad, en, oc;
        logic [2:0] ts, bs, e_top, e_bot;
        logic       e_f;
    } row_s;
    logic pclk = 0, presetn = 0, disch = 0, spd = 0, cur = 0, th = 0, bad = 0, en = 1;
    logic [2:0] uv = 0, ts = 3'h1, bs = 3'h2, top_n, bot, leg;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, fault_n, irq, shorted;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, c0;
    logic e;
    int n_errors = 0, samples_checked = 0;
    row_s rows [8] = '{
        '{3'h0, 0, 0, 1, 0, 3'h1, 3'h2, 3'h6, 3'h2, 1},
        '{3'h4, 0, 0, 1, 0, 3'h1, 3'h2, 3'h7, 3'h0, 0},
        '{3'h2, 0, 0, 1, 0, 3'h1, 3'h2, 3'h7, 3'h0, 0},
        '{3'h1, 0, 0, 1, 0, 3'h1, 3'h2, 3'h7, 3'h0, 0},
        '{3'h0, 1, 0, 1, 0, 3'h1, 3'h2, 3'h0, 3'h0, 0},
        '{3'h0, 0, 0, 0, 0, 3'h1, 3'h2, 3'h0, 3'h0, 0},
        '{3'h0, 0, 1, 1, 0, 3'h1, 3'h2, 3'h7, 3'h0, 0},
        '{3'h0, 0, 0, 1, 1, 3'h4, 3'h1, 3'h3, 3'h0, 0}};
    always #2 pclk = ~pclk;
    motor_pwm_fault_gating uut (
        .pclk(pclk), .presetn(presetn), .ramp_discharge(disch), .speed_cmp(spd),
        .current_cmp(cur), .uv_main_supply_rail(uv[2]), .uv_lowside_supply(uv[1]),
        .uv_reference(uv[0]), .thermal_shutdown(th), .sensor_code_bad(bad),
        .output_enable(en), .top_select(ts), .bottom_select(bs), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .top_drive_n(top_n),
        .bottom_drive(bot), .fault_n(fault_n), .irq(irq));
    power_stage_model stage (.pclk(pclk), .presetn(presetn), .top_drive_n(top_n),
        .bottom_drive(bot), .leg_high(leg), .shorted_q(shorted));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step
    task automatic pulse;
        @(posedge pclk);
        disch <= 1'b1;
        @(posedge pclk);
        disch <= 1'b0;
        step(3);
    endtask : pulse
    // waits on pready only; slave latency is not assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        n_errors++;
        wrap_up();
    end
    initial begin
        step(2);
        chk({top_n, bot, fault_n, irq}, {3'h7, 3'h0, 1'b1, 1'b0});
        step(1);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            {uv, th, bad, en, cur, ts, bs} <= rows[i][19:7];
            pulse();
            chk({top_n, bot, fault_n}, rows[i][6:0]);
        end
        {uv, th, bad, en, cur, ts, bs} <= {3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 3'h2};
        pulse();
        spd <= 1'b1;
        step(2);
        chk({top_n, bot}, {3'h6, 3'h0});
        spd <= 1'b0;
        step(3);
        chk(bot, 3'h0);
        pulse();
        chk(bot, 3'h2);
        cur <= 1'b1;
        step(2);
        chk({bot, fault_n}, {3'h0, 1'b0});
        cur <= 1'b0;
        step(3);
        chk({top_n, bot, fault_n}, {3'h6, 3'h0, 1'b1});
        apb(0, ADDR_MASK, 0);
        chk(r, 32'h0);
        apb(0, ADDR_CYCLES, 0);
        c0 = r;
        pulse();
        apb(0, ADDR_CYCLES, 0);
        chk(r, c0 + 32'h1);
        apb(0, ADDR_EVENT, 0);
        chk(r[0], 1'b1);
        step(2);
        chk(irq, 1'b0);
        apb(1, ADDR_EVENT, 32'hF);
        apb(1, ADDR_MASK, 32'h1);
        cur <= 1'b1;
        step(2);
        cur <= 1'b0;
        step(3);
        chk(irq, 1'b1);
        apb(1, ADDR_EVENT, 32'h1);
        step(3);
        chk(irq, 1'b0);
        apb(1, 12'h020, 32'h1);
        chk(e, 1'b1);
        apb(1, ADDR_CTRL, 32'h1);
        step(2);
        chk({top_n, bot, fault_n}, {3'h0, 3'h0, 1'b0});
        apb(0, ADDR_CTRL, 32'h0);
        chk(r, 32'h0000_0001);
        apb(0, ADDR_STATUS, 32'h0);
        chk(r, 32'h0000_00A0);
        apb(1, ADDR_CTRL, 32'h0);
        chk(shorted, 1'b0);
        // mid-run reset must bring every output back to idle
        presetn <= 1'b0;
        step(2);
        chk({top_n, bot, fault_n, irq}, {3'h7, 3'h0, 1'b1, 1'b0});
        presetn <= 1'b1;
        apb(0, ADDR_CYCLES, 32'h0);
        chk(r, 32'h0);
        wrap_up();
    end
endmodule : tb_motor_pwm_fault_gating
